/* File: program_space_data_window_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end

module program_space_data_window_bench;
    import psw_pkg::*;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic i_page_we = 1'b0;
    logic i_table_busy = 1'b0;
    logic pv;
    logic [15:0] i_core_control_register = 16'h0000;
    logic [7:0] i_page_wdata = 8'h00;
    logic [7:0] page;
    logic [3:0] dly = 4'h1;
    logic [23:0] prd;
    psw_req_t i_req = '0;
    psw_rsp_t o_rsp;
    psw_pmem_req_t o_pmem;
    logic o_stall;
    logic o_data_mem_sel;
    logic [7:0] o_program_window_page;
    int fails = 0;
    int num_checks = 0;
    logic [17:0] exp_q[$];

    always #4 i_clock = ~i_clock;

    psw_window dut (.i_clock(i_clock), .i_srst(i_srst), .i_core_control_register(i_core_control_register),
        .i_page_we(i_page_we), .i_page_wdata(i_page_wdata), .i_table_busy(i_table_busy), .i_req(i_req),
        .o_rsp(o_rsp), .o_stall(o_stall), .o_data_mem_sel(o_data_mem_sel),
        .o_program_window_page(o_program_window_page), .o_pmem(o_pmem), .i_pmem_valid(pv), .i_pmem_rdata(prd));
    psw_pmem_model u_mem (.i_clock(i_clock), .i_pmem(o_pmem), .i_delay(dly), .o_valid(pv), .o_rdata(prd));

    task final_report;
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // one load: cls is {in_repeat, repeat_edge, is_move}
    // ------------------------------------------------------------
    task automatic access(input logic [15:0] ea, input logic [2:0] cls, input logic en, input logic busy);
        int n;
        int st;
        logic win;
        logic [1:0] ex;
        logic [17:0] exp_rsp;
        win = ea[15] & en & ~busy;
        ex = cls[2] ? (cls[1] ? 2'h2 : 2'h0) : (cls[0] ? 2'h1 : 2'h2);
        if (win)
            exp_q.push_back({1'b1, {page, ea[7:0]} ^ 16'h5a5a, 1'b1});
        @(negedge i_clock);
        i_core_control_register = 16'($urandom) & 16'hfffb | {13'h0000, en, 2'h0};
        i_table_busy = busy;
        i_req = '{1'b1, ea, cls[0], cls[2], cls[1]};
        dly = 4'($urandom_range(1, 4));
        @(posedge i_clock);
        #1;
        `CHK(o_pmem.rd, win)
        `CHK(o_data_mem_sel, ~win)
        if (win)
            `CHK(o_pmem.addr, {page, ea[14:0]})
        n = 1;
        st = 0;
        @(negedge i_clock);
        i_req.valid = 1'b0;
        while (win && o_rsp.valid !== 1'b1 && n < 40)
        begin
            st += int'(o_stall);
            @(posedge i_clock);
            #1;
            n++;
        end
        if (n >= 40)
        begin
            fails++;
            final_report();
        end
        if (win)
        begin
            `CHK(n, (ex == 2'h2 ? 4 : 3) + int'(dly))
            `CHK(st, ex == 2'h0 ? 0 : n - 1)
            exp_rsp = exp_q.pop_front();
            `CHK(o_rsp, exp_rsp)
        end
    endtask : access

    initial
    begin
        void'($urandom(9));
        repeat (5) @(posedge i_clock);
        @(negedge i_clock);
        i_srst = 1'b0;
        #1;
        `CHK(o_program_window_page, 8'h00)
        for (int k = 0; k < 48; k++)
        begin
            @(negedge i_clock);
            page = 8'($urandom);
            i_page_we = 1'b1;
            i_page_wdata = page;
            @(negedge i_clock);
            i_page_we = 1'b0;
            `CHK(o_program_window_page, page)
            access(k == 0 ? 16'h8000 : k == 1 ? 16'hffff : k == 2 ? 16'h7fff : 16'($urandom),
                3'(k), k % 5 != 4, k % 7 == 6);
        end
        final_report();
    end
endmodule : program_space_data_window_bench

/* File: psw_pkg.sv */
package psw_pkg;

    // ------------------------------------------------------------
    // widths and address layout
    // ------------------------------------------------------------
    localparam int PSW_EA_W = 16;
    localparam int PSW_DATA_W = 16;
    localparam int PSW_PWORD_W = 24;
    localparam int PSW_PAGE_W = 8;
    localparam int PSW_OFS_W = 15;
    localparam int PSW_PADDR_W = PSW_PAGE_W + PSW_OFS_W;
    localparam int PSW_CORE_CONTROL_REGISTER_W = 16;
    localparam int PSW_EA_TOP_BIT = 15;
    localparam int PSW_ENABLE_BIT = 2;
    localparam logic [PSW_PAGE_W-1:0] PSW_PAGE_RST = 8'h00;
    localparam logic [PSW_CORE_CONTROL_REGISTER_W-1:0] PSW_CORE_CONTROL_REGISTER_RST = 16'h0000;

    // ------------------------------------------------------------
    // stall counts, in instruction cycles
    // ------------------------------------------------------------
    localparam logic [1:0] PSW_STALL_NONE = 2'h0;
    localparam logic [1:0] PSW_STALL_MOVE = 2'h1;
    localparam logic [1:0] PSW_STALL_OTHER = 2'h2;
    localparam logic [1:0] PSW_STALL_REPEAT = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [PSW_EA_W-1:0] effective_address;
        logic is_move;
        logic in_repeat;
        logic repeat_edge;
    } psw_req_t;

    typedef struct packed {
        logic valid;
        logic [PSW_DATA_W-1:0] data;
        logic from_program;
    } psw_rsp_t;

    typedef struct packed {
        logic rd;
        logic [PSW_PADDR_W-1:0] addr;
    } psw_pmem_req_t;

    typedef enum logic [1:0] {
        PSW_IDLE = 2'b00,
        PSW_FETCH = 2'b01,
        PSW_STALL = 2'b10
    } psw_state_t;

endpackage : psw_pkg

/* File: psw_pmem_model.sv */
`timescale 1ns/1ps

module psw_pmem_model
    import psw_pkg::*;
(
    input wire logic i_clock,
    input wire psw_pmem_req_t i_pmem,
    input wire logic [3:0] i_delay,
    output logic o_valid,
    output logic [PSW_PWORD_W-1:0] o_rdata
);
    logic [PSW_PADDR_W-1:0] addr_r;
    logic [3:0] cnt_r = 4'h0;
    initial o_rdata = 24'h00_0000;
    always @(posedge i_clock)
    begin
        o_valid <= 1'b0;
        // idle word toggles so stale data never looks valid
        o_rdata <= ~o_rdata;
        if (i_pmem.rd)
        begin
            addr_r <= i_pmem.addr;
            cnt_r <= i_delay;
        end
        else if (cnt_r != 4'h0)
        begin
            cnt_r <= cnt_r - 4'h1;
            o_valid <= (cnt_r == 4'h1);
            if (cnt_r == 4'h1)
                o_rdata <= {8'hff, {addr_r[22:15], addr_r[7:0]} ^ 16'h5a5a};
        end
    end
endmodule : psw_pmem_model

/* File: psw_stall_calc.sv */
`timescale 1ns/1ps

module psw_stall_calc
(
    // request class
    input wire logic i_is_move,
    input wire logic i_in_repeat,
    input wire logic i_repeat_edge,
    // result
    output logic [1:0] o_extra
);
    import psw_pkg::*;

    always_comb
    begin
        if (!i_in_repeat)
        begin
            o_extra = i_is_move ? PSW_STALL_MOVE : PSW_STALL_OTHER;
        end
        else if (i_repeat_edge)
        begin
            o_extra = PSW_STALL_REPEAT;
        end
        else
        begin
            o_extra = PSW_STALL_NONE;
        end
    end

endmodule : psw_stall_calc

/* File: psw_window.sv */
`timescale 1ns/1ps

module psw_window
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // core control and page
    input wire logic [psw_pkg::PSW_CORE_CONTROL_REGISTER_W-1:0] i_core_control_register,
    input wire logic i_page_we,
    input wire logic [psw_pkg::PSW_PAGE_W-1:0] i_page_wdata,
    input wire logic i_table_busy,
    // core load path
    input wire psw_pkg::psw_req_t i_req,
    output psw_pkg::psw_rsp_t o_rsp,
    output logic o_stall,
    output logic o_data_mem_sel,
    output logic [psw_pkg::PSW_PAGE_W-1:0] o_program_window_page,
    // program memory
    output psw_pkg::psw_pmem_req_t o_pmem,
    input wire logic i_pmem_valid,
    input wire logic [psw_pkg::PSW_PWORD_W-1:0] i_pmem_rdata
);
    import psw_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic program_window_enable;
    logic hit;
    logic [1:0] extra;

    assign program_window_enable = i_core_control_register[PSW_ENABLE_BIT];
    // table transfers own the program memory port, so the window backs off
    assign hit = i_req.valid && i_req.effective_address[PSW_EA_TOP_BIT]
                 && program_window_enable && !i_table_busy;

    psw_stall_calc u_stall
    (
        .i_is_move(i_req.is_move),
        .i_in_repeat(i_req.in_repeat),
        .i_repeat_edge(i_req.repeat_edge),
        .o_extra(extra)
    );

    // ------------------------------------------------------------
    // page register
    // ------------------------------------------------------------
    logic [PSW_PAGE_W-1:0] page_r;
    logic [PSW_PAGE_W-1:0] page_nxt;

    always_comb
    begin
        page_nxt = page_r;
        if (i_page_we)
        begin
            page_nxt = i_page_wdata;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            page_r <= PSW_PAGE_RST;
        end
        else
        begin
            page_r <= page_nxt;
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    psw_state_t state_r;
    psw_state_t state_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic fetch_done;
    logic answer_now;
    logic answer_late;

    // a count of two owes one more cycle after the word arrives
    assign fetch_done = (state_r == PSW_FETCH) && i_pmem_valid;
    assign answer_now = fetch_done && (cnt_r <= 2'h1);
    assign answer_late = (state_r == PSW_STALL);

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            PSW_IDLE:
            begin
                if (hit)
                begin
                    cnt_nxt = extra;
                    state_nxt = PSW_FETCH;
                end
            end
            PSW_FETCH:
            begin
                if (answer_now)
                begin
                    state_nxt = PSW_IDLE;
                end
                else if (fetch_done)
                begin
                    cnt_nxt = cnt_r - 2'h1;
                    state_nxt = PSW_STALL;
                end
            end
            PSW_STALL:
            begin
                cnt_nxt = PSW_STALL_NONE;
                state_nxt = PSW_IDLE;
            end
            default:
            begin
                cnt_nxt = PSW_STALL_NONE;
                state_nxt = PSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state_r <= PSW_IDLE;
            cnt_r <= PSW_STALL_NONE;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // program memory request
    // ------------------------------------------------------------
    psw_pmem_req_t pmem_r;
    psw_pmem_req_t pmem_nxt;

    always_comb
    begin
        pmem_nxt = '0;
        if ((state_r == PSW_IDLE) && hit)
        begin
            pmem_nxt.rd = 1'b1;
            // the offset stays in byte form, as the program counter counts in twos
            pmem_nxt.addr = {page_r, i_req.effective_address[PSW_OFS_W-1:0]};
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            pmem_r <= '0;
        end
        else
        begin
            pmem_r <= pmem_nxt;
        end
    end

    // ------------------------------------------------------------
    // captured read data
    // ------------------------------------------------------------
    logic [PSW_DATA_W-1:0] data_r;
    logic [PSW_DATA_W-1:0] data_nxt;

    always_comb
    begin
        data_nxt = data_r;
        if (fetch_done)
        begin
            // upper byte dropped; it only matters if the words were executed
            data_nxt = i_pmem_rdata[PSW_DATA_W-1:0];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            data_r <= '0;
        end
        else
        begin
            data_r <= data_nxt;
        end
    end

    // ------------------------------------------------------------
    // response to the core
    // ------------------------------------------------------------
    psw_rsp_t rsp_r;
    psw_rsp_t rsp_nxt;

    always_comb
    begin
        rsp_nxt = '0;
        if (answer_now)
        begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data = i_pmem_rdata[PSW_DATA_W-1:0];
            rsp_nxt.from_program = 1'b1;
        end
        else if (answer_late)
        begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data = data_r;
            rsp_nxt.from_program = 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // instruction stretch
    // ------------------------------------------------------------
    logic stall_r;
    logic stall_nxt;

    always_comb
    begin
        stall_nxt = stall_r;
        if (state_r == PSW_IDLE)
        begin
            // a middle repeat iteration owes no cycles, so it never stalls
            stall_nxt = hit && (extra != PSW_STALL_NONE);
        end
        else if (answer_now || (state_r != PSW_FETCH))
        begin
            stall_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            stall_r <= 1'b0;
        end
        else
        begin
            stall_r <= stall_nxt;
        end
    end

    // ------------------------------------------------------------
    // data memory select
    // ------------------------------------------------------------
    logic dsel_r;
    logic dsel_nxt;

    always_comb
    begin
        dsel_nxt = (state_r == PSW_IDLE) && i_req.valid && !hit;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            dsel_r <= 1'b0;
        end
        else
        begin
            dsel_r <= dsel_nxt;
        end
    end

    assign o_rsp = rsp_r;
    assign o_pmem = pmem_r;
    assign o_stall = stall_r;
    assign o_data_mem_sel = dsel_r;
    assign o_program_window_page = page_r;

endmodule : psw_window

/* File: psw_window_sva.sv */
`timescale 1ns/1ps

module psw_window_sva
    import psw_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // control
    input wire logic [PSW_CORE_CONTROL_REGISTER_W-1:0] i_core_control_register,
    input wire logic i_page_we,
    input wire logic [PSW_PAGE_W-1:0] i_page_wdata,
    input wire logic i_table_busy,
    // core side
    input wire psw_req_t i_req,
    input wire psw_rsp_t o_rsp,
    input wire logic o_stall,
    input wire logic o_data_mem_sel,
    input wire logic [PSW_PAGE_W-1:0] o_program_window_page,
    // memory side
    input wire psw_pmem_req_t o_pmem,
    input wire logic i_pmem_valid,
    input wire logic [PSW_PWORD_W-1:0] i_pmem_rdata
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    property p_page; i_page_we |=> o_program_window_page == $past(i_page_wdata); endproperty
    a_page: assert property (p_page) else $error("page load lost");
    property p_addr_hi; o_pmem.rd |-> o_pmem.addr[22:15] == $past(o_program_window_page); endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("page bits wrong");
    property p_addr_lo; o_pmem.rd |-> o_pmem.addr[14:0] == $past(i_req.effective_address[14:0]); endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("offset bits wrong");
    property p_route; o_pmem.rd |-> $past(i_req.effective_address[15] & i_core_control_register[2]); endproperty
    a_route: assert property (p_route) else $error("fetch without window");
    property p_table; o_pmem.rd |-> !$past(i_table_busy); endproperty
    a_table: assert property (p_table) else $error("fetch during table op");
    property p_datasel; o_data_mem_sel |-> !o_pmem.rd && !o_stall && $past(i_req.valid); endproperty
    a_datasel: assert property (p_datasel) else $error("data path stalled");
    property p_lag; i_pmem_valid |-> ##[1:2] o_rsp.valid; endproperty
    a_lag: assert property (p_lag) else $error("late answer");
    property p_stall_end; $fell(o_stall) |-> o_rsp.valid; endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall dropped early");
    property p_repeat; o_pmem.rd |-> o_stall == !($past(i_req.in_repeat) && !$past(i_req.repeat_edge)); endproperty
    a_repeat: assert property (p_repeat) else $error("repeat stall wrong");
endmodule : psw_window_sva

bind psw_window psw_window_sva u_sva (.*);
